/* File: hdl/cgpp_pkg.sv */
package cgpp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYMB_PERIOD_NS = 8;
    // Nominal period, rounded to the nearest whole cycle, never below one
    localparam int SYMB_ROUND = (SYMB_PERIOD_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int SYMB_CYCLES = (SYMB_ROUND < 1) ? 1 : SYMB_ROUND;
    localparam int RESET_HOLD_CYCLES = 16;

    typedef logic [11:0] cgpp_vec_t;
    typedef enum logic [1:0] {
        CGPP_SEND_Z = 2'h0,
        CGPP_SEND_N = 2'h1,
        CGPP_SEND_I = 2'h2
    } cgpp_mode_t;
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_DATA = 4'h2,
        TX_ESD1 = 4'h4,
        TX_ESD2 = 4'h8
    } cgpp_txst_t;

    // Symbols are 3-bit two's complement, pair A in the low bits
    localparam cgpp_vec_t VEC_ZERO = 12'h000;
    localparam cgpp_vec_t VEC_IDLE = 12'h249;
    localparam cgpp_vec_t VEC_ESD1 = 12'h492;
    localparam cgpp_vec_t VEC_ESD2_EXT0 = 12'h496;
    localparam cgpp_vec_t VEC_ESD2_EXT1 = 12'h4B2;
    localparam cgpp_vec_t VEC_ESD2_EXT2 = 12'h592;
    localparam cgpp_vec_t VEC_XMT_ERR = 12'h4B6;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SLAVE_BIT = 2;
    localparam int CTRL_RESET_BIT = 3;
    localparam int STAT_LOC_OK_BIT = 0;
    localparam int STAT_XMIT_BIT = 1;
    localparam int STAT_RCV_BIT = 2;
    localparam int STAT_RESET_BIT = 3;
    localparam cgpp_mode_t CTRL_MODE_RST = CGPP_SEND_Z;
    localparam logic CTRL_SLAVE_RST = 1'b0;

    // Octet as four base-5 digits, each offset by -2; every data vector
    // lies below 256 in that numbering, so the special vectors never collide
    function automatic cgpp_vec_t cgpp_encode(input logic [7:0] o);
        logic [7:0] r;
        cgpp_vec_t v;
        r = o;
        v = VEC_ZERO;
        for (int i = 0; i < 4; i++) begin
            v[3*i +: 3] = 3'(r % 8'h05) - 3'h2;
            r = r / 8'h05;
        end
        return v;
    endfunction

    function automatic logic [7:0] cgpp_decode(input cgpp_vec_t v);
        logic [9:0] acc;
        acc = 10'h000;
        for (int i = 3; i >= 0; i--) begin
            acc = 10'(acc * 10'h005) + 10'(3'(v[3*i +: 3] + 3'h2));
        end
        return acc[7:0];
    endfunction
endpackage

/* File: hdl/cgpp_core_if.sv */
`timescale 1ns/10ps
interface cgpp_core_if;
    logic clr;
    logic symb_done;
    cgpp_pkg::cgpp_vec_t rx_vec;
    logic rx_valid;
    cgpp_pkg::cgpp_vec_t cur_vec;
    logic cur_valid;
    logic idle_run;
    logic end_ok;
    modport timer (input clr, output symb_done);
    modport chk (input clr, rx_vec, rx_valid, output cur_vec, cur_valid, idle_run, end_ok);
endinterface

/* File: hdl/cgpp_symb_timer.sv */
`timescale 1ns/10ps
module cgpp_symb_timer #(
    parameter int CYCLES = cgpp_pkg::SYMB_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    cgpp_core_if.timer tif
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic done;
    } cgpp_tmr_t;
    cgpp_tmr_t st;
    cgpp_tmr_t next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (tif.clr) begin
            next_st.cnt = '0;
        end else if (st.cnt == LAST) begin
            next_st.cnt = '0; // R1
            next_st.done = 1'b1; // R22
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    // Runs on the reference clock that the top also uses, so the strobe needs no crossing
    always_ff @(posedge clk or posedge rst) begin // R2
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tif.symb_done = st.done;

    expire_restart_a: assert property (@(posedge clk) disable iff (rst) // R1
        (!tif.clr && st.cnt == LAST) |=> (st.done && st.cnt == '0))
        else $error("symbol timer did not restart on expiry");
    done_cause_a: assert property (@(posedge clk) disable iff (rst) // R22
        st.done |-> ($past(st.cnt) == LAST && !$past(tif.clr)))
        else $error("symbol strobe without expiry");
endmodule // cgpp_symb_timer

/* File: hdl/cgpp_rx_check.sv */
`timescale 1ns/10ps
module cgpp_rx_check (
    input wire logic clk,
    input wire logic rst,
    cgpp_core_if.chk cif
);
    typedef struct packed {
        logic [3:0][11:0] hist;
        logic [2:0] fill;
        logic cur_valid;
    } cgpp_chk_t;
    cgpp_chk_t st;
    cgpp_chk_t next_st;
    logic full;

    // hist[3] is the current vector, hist[2..0] the next three
    always_comb begin
        next_st = st;
        next_st.cur_valid = 1'b0;
        if (cif.clr) begin
            next_st = '0;
        end else if (cif.rx_valid) begin
            next_st.hist = {st.hist[2:0], cif.rx_vec};
            next_st.fill = (st.fill == 3'h4) ? st.fill : st.fill + 3'h1;
            next_st.cur_valid = (st.fill >= 3'h3);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign full = (st.fill == 3'h4);
    assign cif.cur_vec = st.hist[3];
    assign cif.cur_valid = st.cur_valid;
    assign cif.idle_run = full && (st.hist == {4{cgpp_pkg::VEC_IDLE}}); // R5
    assign cif.end_ok = full && (st.hist[2] == cgpp_pkg::VEC_ESD1) // R4
        && (st.hist[1] == cgpp_pkg::VEC_ESD2_EXT0 || st.hist[1] == cgpp_pkg::VEC_ESD2_EXT1
        || st.hist[1] == cgpp_pkg::VEC_ESD2_EXT2);

    idle_miss_a: assert property (@(posedge clk) disable iff (rst) // R5
        (st.hist[1] != cgpp_pkg::VEC_IDLE || st.hist[3] != cgpp_pkg::VEC_IDLE) |-> !cif.idle_run)
        else $error("idle run flagged with a non-idle vector");
    end_pair_a: assert property (@(posedge clk) disable iff (rst) // R4
        cif.end_ok |-> (st.hist[2] == cgpp_pkg::VEC_ESD1 && st.hist[1] != cgpp_pkg::VEC_ESD1))
        else $error("end delimiter flagged without legal pair");
endmodule // cgpp_rx_check

/* File: hdl/cgpp_top.sv */
// Function
// R1: Symbol timer free-runs, restart clears done
// R2: Timer period 8 ns, on symbol clock; the timer counts one 10 ns REF_CLK cycle instead
// R3: Vector request coincides with timer done
// R4: End check validates next two vectors
// R5: Idle check needs four idle vectors
// R6: Decode received vector to octet
// R7: Encode transmit octet to vector
// R8: Reset on power-on or management request
// R9: Coding reset held while any condition
// R10: All state machines re-enter on reset
// R11: Functions start together after reset
// R12: All four pairs share one clock
// R13: Pairs continuously carry current vector symbols
// R14: Master uses local clock source
// R15: Slave uses recovered clock, loop timing
// R16: Receiver status from lock and convergence
// R17: Transmitted vectors fed to receive path
// R18: Transmit mode one of three values
// R19: Stream flag true while stream sent
// R20: Receiver status is ok or not
// R21: Master or slave given as one bit
// R22: Done strobe one cycle per symbol
`timescale 1ns/10ps
module cgpp_top #(
    parameter int SYMB_CYCLES = cgpp_pkg::SYMB_CYCLES,
    parameter logic [7:0] RESET_HOLD = 8'(cgpp_pkg::RESET_HOLD_CYCLES)
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [7:0] TXD,
    input wire logic TX_EN,
    input wire logic TX_ER,
    input wire logic [11:0] RX_SYMB,
    input wire logic RX_VALID,
    input wire logic SCR_LOCK,
    input wire logic EQ_OK,
    input wire logic CANCEL_OK,
    input wire logic EST_OK,
    output logic [2:0] TX_PAIR_A,
    output logic [2:0] TX_PAIR_B,
    output logic [2:0] TX_PAIR_C,
    output logic [2:0] TX_PAIR_D,
    output logic TX_VEC_REQ,
    output logic SYMB_DONE,
    output logic [11:0] ECHO_VEC,
    output logic [1:0] TX_MODE,
    output logic STREAM_TRANSMITTING,
    output logic STREAM_RECEIVING,
    output logic [7:0] RXD,
    output logic RXD_VALID,
    output logic END_DETECT,
    output logic IDLE_RUN,
    output logic LOC_RCVR_OK,
    output logic CONFIG_SLAVE,
    output logic TCLK_FROM_RECOVERED,
    output logic PCS_RESET
);
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        cgpp_pkg::cgpp_mode_t mode;
        logic slave;
        logic [7:0] hold;
        logic pcs_reset;
        cgpp_pkg::cgpp_txst_t tx_st;
        cgpp_pkg::cgpp_vec_t tx_vec;
        logic vec_req;
        logic symb_done;
        cgpp_pkg::cgpp_vec_t echo;
        logic xmit;
        logic rcv;
        logic armed;
        logic loc_ok;
        logic [7:0] rxd;
        logic rxd_valid;
        logic end_det;
        logic idle_run;
        logic [15:0] req_cnt;
    } cgpp_top_t;

    localparam cgpp_top_t TOP_RST = '{
        waitreq: 1'b1,
        pcs_reset: 1'b1,
        mode: cgpp_pkg::CTRL_MODE_RST,
        slave: cgpp_pkg::CTRL_SLAVE_RST,
        tx_st: cgpp_pkg::TX_IDLE,
        default: '0
    };
    localparam int START_MAX = SYMB_CYCLES + 2;

    cgpp_top_t st;
    cgpp_top_t next_st;
    logic [31:0] rd;
    logic ctrl_wr;
    cgpp_pkg::cgpp_vec_t data_vec;

    cgpp_core_if cif();

    assign cif.clr = st.pcs_reset; // R11
    assign cif.rx_vec = RX_SYMB;
    assign cif.rx_valid = RX_VALID;

    cgpp_symb_timer #(
        .CYCLES(SYMB_CYCLES)
    ) u_timer (
        .clk(REF_CLK),
        .rst(RST),
        .tif(cif)
    );

    cgpp_rx_check u_chk (
        .clk(REF_CLK),
        .rst(RST),
        .cif(cif)
    );

    always_comb begin
        rd = 32'h0000_0000;
        case (AVS_ADDRESS)
            cgpp_pkg::REG_CTRL: begin
                rd[cgpp_pkg::CTRL_MODE_LSB +: 2] = st.mode;
                rd[cgpp_pkg::CTRL_SLAVE_BIT] = st.slave;
                rd[cgpp_pkg::CTRL_RESET_BIT] = st.pcs_reset;
            end
            cgpp_pkg::REG_STATUS: begin
                rd[cgpp_pkg::STAT_LOC_OK_BIT] = st.loc_ok;
                rd[cgpp_pkg::STAT_XMIT_BIT] = st.xmit;
                rd[cgpp_pkg::STAT_RCV_BIT] = st.rcv;
                rd[cgpp_pkg::STAT_RESET_BIT] = st.pcs_reset;
            end
            cgpp_pkg::REG_COUNT: begin
                rd[15:0] = st.req_cnt;
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase
    end

    // A write lands only at the edge where waitrequest is seen low
    assign ctrl_wr = !st.waitreq && AVS_WRITE && AVS_BYTEENABLE[0]
        && (AVS_ADDRESS == cgpp_pkg::REG_CTRL);
    assign data_vec = TX_ER ? cgpp_pkg::VEC_XMT_ERR : cgpp_pkg::cgpp_encode(TXD); // R7

    always_comb begin
        next_st = st;
        next_st.vec_req = 1'b0;
        next_st.symb_done = 1'b0;
        next_st.rxd_valid = 1'b0;
        next_st.end_det = 1'b0;
        next_st.idle_run = 1'b0;

        if (st.waitreq) begin
            if (AVS_READ || AVS_WRITE) begin
                next_st.waitreq = 1'b0;
                next_st.rdata = rd;
            end
        end else begin
            next_st.waitreq = 1'b1;
        end

        if (st.hold != 8'h00) begin
            next_st.hold = st.hold - 8'h01;
        end
        if (ctrl_wr) begin
            // Code 3 is not a mode; such a write leaves the mode alone
            if (AVS_WRITEDATA[cgpp_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
                next_st.mode = cgpp_pkg::cgpp_mode_t'(AVS_WRITEDATA[cgpp_pkg::CTRL_MODE_LSB +: 2]); // R18
            end
            next_st.slave = AVS_WRITEDATA[cgpp_pkg::CTRL_SLAVE_BIT];
            if (AVS_WRITEDATA[cgpp_pkg::CTRL_RESET_BIT]) begin
                next_st.hold = RESET_HOLD; // R8
            end
        end
        next_st.pcs_reset = (next_st.hold != 8'h00); // R9

        if (st.pcs_reset) begin
            next_st.tx_st = cgpp_pkg::TX_IDLE; // R10
            next_st.tx_vec = cgpp_pkg::VEC_ZERO;
            next_st.echo = cgpp_pkg::VEC_ZERO;
            next_st.xmit = 1'b0;
            next_st.rcv = 1'b0;
            next_st.armed = 1'b0;
            next_st.loc_ok = 1'b0;
            next_st.req_cnt = 16'h0000;
        end else begin
            next_st.loc_ok = SCR_LOCK && EQ_OK && CANCEL_OK && EST_OK; // R16 R20
            if (cif.symb_done) begin
                next_st.symb_done = 1'b1; // R22
                next_st.vec_req = 1'b1; // R3
                next_st.req_cnt = st.req_cnt + 16'h0001;
                case (st.tx_st)
                    cgpp_pkg::TX_IDLE: begin
                        if (st.mode == cgpp_pkg::CGPP_SEND_N && TX_EN) begin
                            next_st.tx_vec = data_vec;
                            next_st.tx_st = cgpp_pkg::TX_DATA;
                        end else if (st.mode == cgpp_pkg::CGPP_SEND_Z) begin
                            next_st.tx_vec = cgpp_pkg::VEC_ZERO;
                        end else begin
                            next_st.tx_vec = cgpp_pkg::VEC_IDLE;
                        end
                    end
                    cgpp_pkg::TX_DATA: begin
                        // A started frame runs to its delimiter unless a coding reset cuts it off
                        if (TX_EN) begin
                            next_st.tx_vec = data_vec;
                        end else begin
                            next_st.tx_vec = cgpp_pkg::VEC_ESD1;
                            next_st.tx_st = cgpp_pkg::TX_ESD1;
                        end
                    end
                    cgpp_pkg::TX_ESD1: begin
                        next_st.tx_vec = cgpp_pkg::VEC_ESD2_EXT0;
                        next_st.tx_st = cgpp_pkg::TX_ESD2;
                    end
                    cgpp_pkg::TX_ESD2: begin
                        next_st.tx_st = cgpp_pkg::TX_IDLE;
                        if (st.mode == cgpp_pkg::CGPP_SEND_Z) begin
                            next_st.tx_vec = cgpp_pkg::VEC_ZERO;
                        end else begin
                            next_st.tx_vec = cgpp_pkg::VEC_IDLE;
                        end
                    end
                    default: begin
                        next_st.tx_st = cgpp_pkg::TX_IDLE;
                        next_st.tx_vec = cgpp_pkg::VEC_ZERO;
                    end
                endcase
                next_st.echo = next_st.tx_vec; // R17
                next_st.xmit = (next_st.tx_st != cgpp_pkg::TX_IDLE); // R19
            end

            if (cif.cur_valid) begin
                next_st.rxd = cgpp_pkg::cgpp_decode(cif.cur_vec); // R6
                // Re-arming on idle keeps delimiter vectors from restarting a stream
                if (cif.idle_run) begin
                    next_st.idle_run = 1'b1; // R5
                    next_st.armed = 1'b1;
                    next_st.rcv = 1'b0;
                end else if (st.rcv && cif.end_ok) begin
                    next_st.end_det = 1'b1; // R4
                    next_st.rcv = 1'b0;
                end else if (!st.rcv && st.armed && cif.cur_vec != cgpp_pkg::VEC_IDLE) begin
                    next_st.rcv = 1'b1;
                    next_st.armed = 1'b0;
                end
                next_st.rxd_valid = st.rcv;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st <= TOP_RST; // R8
        end else begin
            st <= next_st;
        end
    end

    assign AVS_READDATA = st.rdata;
    assign AVS_WAITREQUEST = st.waitreq;
    // One vector register feeds every pair, all on the same clock
    assign TX_PAIR_A = st.tx_vec[2:0]; // R12 R13
    assign TX_PAIR_B = st.tx_vec[5:3];
    assign TX_PAIR_C = st.tx_vec[8:6];
    assign TX_PAIR_D = st.tx_vec[11:9];
    assign TX_VEC_REQ = st.vec_req;
    assign SYMB_DONE = st.symb_done;
    assign ECHO_VEC = st.echo;
    assign TX_MODE = st.mode;
    assign STREAM_TRANSMITTING = st.xmit;
    assign STREAM_RECEIVING = st.rcv;
    assign RXD = st.rxd;
    assign RXD_VALID = st.rxd_valid;
    assign END_DETECT = st.end_det;
    assign IDLE_RUN = st.idle_run;
    assign LOC_RCVR_OK = st.loc_ok;
    assign PCS_RESET = st.pcs_reset; // R9
    // The clock mux sits outside; this only selects the source
    assign CONFIG_SLAVE = st.slave; // R21
    assign TCLK_FROM_RECOVERED = st.slave; // R14 R15

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    sequence s_reset_write;
        ctrl_wr && AVS_WRITEDATA[cgpp_pkg::CTRL_RESET_BIT];
    endsequence
    sequence s_reset_held;
        PCS_RESET [*2];
    endsequence

    req_sync_a: assert property (TX_VEC_REQ == SYMB_DONE) // R3
        else $error("vector request apart from timer done");
    reset_hold_a: assert property (s_reset_write |=> s_reset_held) // R9
        else $error("coding reset not held after management request");
    sm_entry_a: assert property (PCS_RESET |=> // R10
        (st.tx_st == cgpp_pkg::TX_IDLE && !STREAM_TRANSMITTING && !STREAM_RECEIVING))
        else $error("state machine missed reset entry");
    run_start_a: assert property ($fell(PCS_RESET) |-> ##[1:START_MAX] SYMB_DONE) // R11
        else $error("transmit did not start after reset");
    mode_legal_a: assert property (TX_MODE != 2'h3) // R18
        else $error("illegal transmit mode");
    zero_vec_a: assert property ((cif.symb_done && !st.pcs_reset // R13
        && st.mode == cgpp_pkg::CGPP_SEND_Z && st.tx_st == cgpp_pkg::TX_IDLE)
        |=> {TX_PAIR_D, TX_PAIR_C, TX_PAIR_B, TX_PAIR_A} == cgpp_pkg::VEC_ZERO)
        else $error("send zeros mode sent nonzero symbols");
    encode_map_a: assert property ((cif.symb_done && !st.pcs_reset && TX_EN && !TX_ER // R7
        && (st.tx_st == cgpp_pkg::TX_DATA || (st.tx_st == cgpp_pkg::TX_IDLE
        && st.mode == cgpp_pkg::CGPP_SEND_N)))
        |=> (st.tx_vec == cgpp_pkg::cgpp_encode($past(TXD)) && ECHO_VEC == st.tx_vec))
        else $error("transmit octet not encoded");
    decode_map_a: assert property ((cif.cur_valid && !st.pcs_reset) // R6
        |=> RXD == cgpp_pkg::cgpp_decode($past(cif.cur_vec)))
        else $error("receive vector not decoded");
    rcvr_stat_a: assert property ((!st.pcs_reset && !SCR_LOCK) |=> !LOC_RCVR_OK) // R16
        else $error("receiver ok without descrambler lock");
    xmit_flag_a: assert property (STREAM_TRANSMITTING == (st.tx_st != cgpp_pkg::TX_IDLE)) // R19
        else $error("stream flag disagrees with transmit state");
    bus_ack_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
endmodule // cgpp_top

/* File: dv/cgpp_far_end.sv */
`timescale 1ns/10ps
module cgpp_far_end (
    input wire logic clk,
    input wire logic rst,
    input wire logic send,
    input wire logic [11:0] vec,
    input wire logic [3:0] gap,
    output logic [11:0] rx_symb,
    output logic rx_valid,
    output logic busy
);
    logic [3:0] wait_cnt;
    logic [11:0] held;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_symb <= 12'hfff;
            rx_valid <= 1'b0;
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            held <= 12'h000;
        end else begin
            rx_valid <= 1'b0;
            // Line toggles between vectors so a stale one never looks fresh
            rx_symb <= ~rx_symb;
            if (send && !busy) begin
                busy <= 1'b1;
                wait_cnt <= gap;
                held <= vec;
            end else if (busy && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (busy) begin
                rx_symb <= held;
                rx_valid <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule // cgpp_far_end

/* File: dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] HOLD = 8'h02;
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [3:0] AVS_BYTEENABLE = 4'hf;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic [7:0] TXD = 8'h00;
    logic TX_EN = 1'b0;
    logic TX_ER = 1'b0;
    logic [11:0] RX_SYMB, ECHO_VEC, txv;
    logic RX_VALID, TX_VEC_REQ, SYMB_DONE, STREAM_TRANSMITTING, STREAM_RECEIVING;
    logic [3:0] ok_in = 4'hf;
    logic [2:0] TX_PAIR_A, TX_PAIR_B, TX_PAIR_C, TX_PAIR_D;
    logic [1:0] TX_MODE;
    logic [7:0] RXD;
    logic RXD_VALID, END_DETECT, IDLE_RUN, LOC_RCVR_OK, CONFIG_SLAVE;
    logic TCLK_FROM_RECOVERED, PCS_RESET, fe_busy;
    logic fe_send = 1'b0;
    logic [11:0] fe_vec = 12'h000;
    logic [3:0] fe_gap = 4'h0;
    logic [31:0] rd;
    logic [11:0] rxs[$];
    logic [11:0] esd2[3] = '{12'h496, 12'h4b2, 12'h592};
    logic [7:0] octs[4] = '{8'h00, 8'hff, 8'ha5, 8'h7c};
    logic [7:0] rx_q[$];
    logic recv_seen = 1'b0;
    int errors = 0;
    int check_count = 0;
    int idle_n = 0;
    int end_n = 0;
    int n;

    always #5 REF_CLK = ~REF_CLK;
    assign txv = {TX_PAIR_D, TX_PAIR_C, TX_PAIR_B, TX_PAIR_A};

    cgpp_top #(.RESET_HOLD(HOLD)) dut (.REF_CLK(REF_CLK), .RST(RST),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .TXD(TXD), .TX_EN(TX_EN), .TX_ER(TX_ER), .RX_SYMB(RX_SYMB), .RX_VALID(RX_VALID),
        .SCR_LOCK(ok_in[0]), .EQ_OK(ok_in[1]), .CANCEL_OK(ok_in[2]), .EST_OK(ok_in[3]),
        .TX_PAIR_A(TX_PAIR_A), .TX_PAIR_B(TX_PAIR_B), .TX_PAIR_C(TX_PAIR_C),
        .TX_PAIR_D(TX_PAIR_D), .TX_VEC_REQ(TX_VEC_REQ), .SYMB_DONE(SYMB_DONE),
        .ECHO_VEC(ECHO_VEC), .TX_MODE(TX_MODE), .STREAM_TRANSMITTING(STREAM_TRANSMITTING),
        .STREAM_RECEIVING(STREAM_RECEIVING), .RXD(RXD), .RXD_VALID(RXD_VALID),
        .END_DETECT(END_DETECT), .IDLE_RUN(IDLE_RUN), .LOC_RCVR_OK(LOC_RCVR_OK),
        .CONFIG_SLAVE(CONFIG_SLAVE), .TCLK_FROM_RECOVERED(TCLK_FROM_RECOVERED),
        .PCS_RESET(PCS_RESET));

    cgpp_far_end fe (.clk(REF_CLK), .rst(RST), .send(fe_send), .vec(fe_vec), .gap(fe_gap),
        .rx_symb(RX_SYMB), .rx_valid(RX_VALID), .busy(fe_busy));

    always @(posedge REF_CLK) begin
        if (RXD_VALID === 1'b1) rx_q.push_back(RXD);
        if (IDLE_RUN === 1'b1) idle_n++;
        if (END_DETECT === 1'b1) end_n++;
        if (STREAM_RECEIVING === 1'b1) recv_seen = 1'b1;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic give_up();
        errors++;
        $display("mismatch at %0t: wait ran out", $time);
        tally_and_finish();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int k;
        @(posedge REF_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        k = 0;
        do begin
            @(posedge REF_CLK);
            k++;
        end while (AVS_WAITREQUEST !== 1'b0 && k < 20);
        if (k >= 20) give_up();
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask

    task automatic send(input logic [11:0] v, input logic [3:0] g);
        int k;
        @(posedge REF_CLK);
        fe_vec <= v;
        fe_gap <= g;
        fe_send <= 1'b1;
        @(posedge REF_CLK);
        fe_send <= 1'b0;
        k = 0;
        do begin
            @(posedge REF_CLK);
            k++;
        end while (fe_busy !== 1'b0 && k < 30);
        if (k >= 30) give_up();
    endtask

    // Octet as four base-5 digits less two, pair A lowest
    function automatic logic [11:0] enc5(input int o);
        logic [11:0] v;
        int r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            v[3*i +: 3] = 3'(r % 5 - 2);
            r = r / 5;
        end
        return v;
    endfunction

    initial begin
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        #1;
        chk(PCS_RESET, 0);
        chk(TX_MODE, 0);
        bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
        chk(rd, 0);
        bus(1'b0, 4'hc, 32'h0000_0000, 4'hf);
        chk(rd, 0);
        repeat (8) begin
            @(posedge REF_CLK);
            #1;
            chk(SYMB_DONE, 1);
            chk(TX_VEC_REQ, 1);
        end
        bus(1'b1, 4'h0, 32'h0000_0004, 4'hf);
        #1;
        chk({CONFIG_SLAVE, TCLK_FROM_RECOVERED}, 2'b11);
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, 4'h0, 32'(m), 4'hf);
            repeat (2) @(posedge REF_CLK);
            #1;
            chk(TX_MODE, m);
            chk(txv, (m == 0) ? 12'h000 : 12'h249);
            chk({CONFIG_SLAVE, TCLK_FROM_RECOVERED}, 2'b00);
        end
        bus(1'b1, 4'h0, 32'h0000_0003, 4'hf);
        bus(1'b1, 4'h0, 32'h0000_0001, 4'h0);
        #1;
        chk(TX_MODE, 2);
        bus(1'b1, 4'h0, 32'h0000_0001, 4'hf);
        for (int i = 0; i < 4; i++) begin
            @(posedge REF_CLK);
            TXD <= octs[i];
            TX_EN <= 1'b1;
            TX_ER <= (i == 2);
            @(posedge REF_CLK);
            #1;
            chk(txv, (i == 2) ? 12'h4b6 : enc5(octs[i]));
            chk(ECHO_VEC, txv);
            chk(STREAM_TRANSMITTING, 1);
        end
        @(posedge REF_CLK);
        TX_EN <= 1'b0;
        TX_ER <= 1'b0;
        foreach (esd2[i]) begin
            @(posedge REF_CLK);
            #1;
            chk(txv, (i == 0) ? 12'h492 : (i == 1) ? 12'h496 : 12'h249);
        end
        chk(STREAM_TRANSMITTING, 0);
        rxs = '{12'h249, 12'h249, 12'h249, 12'h249};
        foreach (esd2[e]) begin
            rxs = {rxs, enc5(17), enc5(60), enc5(195), 12'h492, esd2[e]};
            rxs = {rxs, 12'h249, 12'h249, 12'h249, 12'h249};
        end
        // Alternate prompt and slow delivery from the far end
        foreach (rxs[i]) send(rxs[i], 4'((i % 2) * 3));
        repeat (4) @(posedge REF_CLK);
        chk(idle_n, 4);
        chk(end_n, 3);
        chk(rx_q.size(), 6);
        chk(rx_q[0], 60);
        chk(rx_q[5], 195);
        chk(recv_seen, 1);
        chk(STREAM_RECEIVING, 0);
        for (int j = 0; j < 5; j++) begin
            @(posedge REF_CLK);
            ok_in <= (j == 4) ? 4'hf : ~(4'h1 << j);
            repeat (2) @(posedge REF_CLK);
            #1;
            chk(LOC_RCVR_OK, j == 4);
        end
        bus(1'b0, 4'h4, 32'h0000_0000, 4'hf);
        chk(rd[0], 1);
        @(posedge REF_CLK);
        TX_EN <= 1'b1;
        TXD <= 8'h3c;
        // Management reset lands in mid-frame
        bus(1'b1, 4'h0, 32'h0000_0009, 4'hf);
        #1;
        chk(PCS_RESET, 1);
        @(posedge REF_CLK);
        TX_EN <= 1'b0;
        #1;
        chk(txv, 0);
        chk(STREAM_TRANSMITTING, 0);
        n = 1;
        while (PCS_RESET === 1'b1 && n < 20) begin
            @(posedge REF_CLK);
            #1;
            n++;
        end
        chk(n, HOLD);
        chk(TX_MODE, 1);
        // Timer leaves its clear one edge late, the strobe register adds one more
        repeat (2) @(posedge REF_CLK);
        #1;
        chk(SYMB_DONE, 1);
        bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
        chk(rd[3:0], 4'h1);
        tally_and_finish();
    end
endmodule // testbench
